/* hw/cpvm_mapper.sv */
// packet framer, channel remapper and transmitter steering for four camera ports
module cpvm_mapper
  import cpvm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [1:0] reg_port_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [cpvm_pkg::NUM_PORTS-1:0] req_valid_i,
  input wire logic [cpvm_pkg::NUM_PORTS-1:0] req_long_i,
  input wire logic [cpvm_pkg::NUM_PORTS-1:0] req_twelve_bit_i,
  input wire logic [2*cpvm_pkg::NUM_PORTS-1:0] req_sync_i,
  input wire logic [16*cpvm_pkg::NUM_PORTS-1:0] req_wc_i,
  output logic [cpvm_pkg::NUM_PORTS-1:0] req_ready_o,
  input wire logic [cpvm_pkg::NUM_PORTS-1:0] pay_valid_i,
  input wire logic [8*cpvm_pkg::NUM_PORTS-1:0] pay_data_i,
  output logic [cpvm_pkg::NUM_PORTS-1:0] pay_ready_o,
  output logic [cpvm_pkg::NUM_TX-1:0] tx_valid_o,
  output logic [8*cpvm_pkg::NUM_TX-1:0] tx_data_o,
  output logic [cpvm_pkg::NUM_TX-1:0] tx_first_o,
  output logic [cpvm_pkg::NUM_TX-1:0] tx_last_o,
  input wire logic [cpvm_pkg::NUM_TX-1:0] tx_ready_i,
  output logic [1:0] lane_rate_o,
  output logic timing_auto_o
);
  import cpvm_pkg::*;

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [7:0] ten_bit_id_reg [NUM_PORTS];
  logic [7:0] twelve_bit_id_reg [NUM_PORTS];
  logic [7:0] remap_reg [NUM_PORTS];
  logic [RATE_W-1:0] lane_rate_reg;
  logic [NUM_PORTS-1:0] port_tx_reg;
  logic timing_ovr_reg;
  logic [7:0] rdata_reg;
  logic [NUM_PORTS-1:0] grant_w [NUM_TX];
  logic [NUM_PORTS-1:0] pay_rdy_w [NUM_TX];
  logic [NUM_TX-1:0] busy_w;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        ten_bit_id_reg[p] <= RST_STREAM_ID;
        twelve_bit_id_reg[p] <= RST_STREAM_ID;
        remap_reg[p] <= RST_REMAP;
      end
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_TEN_BIT_ID: ten_bit_id_reg[reg_port_i] <= reg_wdata_i;
        ADDR_TWELVE_BIT_ID: twelve_bit_id_reg[reg_port_i] <= reg_wdata_i;
        ADDR_REMAP: remap_reg[reg_port_i] <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lane_rate_reg <= RST_LANE_RATE;
      port_tx_reg <= RST_PORT_TX;
      timing_ovr_reg <= RST_TIMING_OVR;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_LANE_RATE: lane_rate_reg <= reg_wdata_i[RATE_W-1:0];
        ADDR_PORT_TX: port_tx_reg <= reg_wdata_i[NUM_PORTS-1:0];
        ADDR_TIMING_OVR: timing_ovr_reg <= reg_wdata_i[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // read path and status outputs
  // ----------------------------------------------------------------------
  // read data is registered, so it trails the address by one edge
  // a read has no strobe, so the mux follows the address every cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= 8'h00;
    end else begin
      case (reg_addr_i)
        ADDR_LANE_RATE: rdata_reg <= {6'h00, lane_rate_reg};
        ADDR_PORT_TX: rdata_reg <= {4'h0, port_tx_reg};
        ADDR_TIMING_OVR: rdata_reg <= {7'h00, timing_ovr_reg};
        ADDR_STATUS: rdata_reg <= {6'h00, busy_w};
        ADDR_TEN_BIT_ID: rdata_reg <= ten_bit_id_reg[reg_port_i];
        ADDR_TWELVE_BIT_ID: rdata_reg <= twelve_bit_id_reg[reg_port_i];
        ADDR_REMAP: rdata_reg <= remap_reg[reg_port_i];
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign lane_rate_o = lane_rate_reg;
  // reserved code gets no automatic timing; 400 Mbps relies on host values
  assign timing_auto_o = ((lane_rate_reg == RATE_1G6) || (lane_rate_reg == RATE_800M))
                         && !timing_ovr_reg;

  // each port sits on one transmitter, so at most one engine grants it
  always_comb begin
    req_ready_o = '0;
    pay_ready_o = '0;
    for (int t = 0; t < NUM_TX; t++) begin
      req_ready_o = req_ready_o | grant_w[t];
      pay_ready_o = pay_ready_o | pay_rdy_w[t];
    end
  end

  // ----------------------------------------------------------------------
  // one framing engine per transmitter
  // ----------------------------------------------------------------------
  for (genvar t = 0; t < NUM_TX; t++) begin : g_tx
    cpvm_state_t state_reg;
    logic [PORT_W-1:0] sel_reg;
    logic [PORT_W-1:0] rr_reg;
    logic [31:0] hdr_reg;
    logic [1:0] hdr_cnt_reg;
    logic is_long_reg;
    logic [15:0] left_reg;
    logic [15:0] crc_reg;
    logic ftr_cnt_reg;
    logic out_valid_reg;
    logic [7:0] out_data_reg;
    logic out_first_reg;
    logic out_last_reg;
    logic load;
    logic take;
    logic any_req;
    logic [PORT_W-1:0] pick;
    logic [7:0] id_byte;
    logic [VC_W-1:0] in_vc;
    logic [VC_W-1:0] out_vc;
    logic [DT_W-1:0] dt;
    logic [15:0] wc;

    // a held byte blocks the engine, so nothing is lost when the sink stalls
    assign load = !out_valid_reg || tx_ready_i[t];
    assign busy_w[t] = (state_reg != ST_IDLE);

    // round robin from the port after the last winner, among ports on this transmitter
    always_comb begin
      logic [PORT_W-1:0] idx;
      idx = '0;
      any_req = 1'b0;
      pick = '0;
      for (int k = NUM_PORTS; k >= 1; k--) begin
        idx = PORT_W'(rr_reg + PORT_W'(k));
        if (req_valid_i[idx] && (port_tx_reg[idx] == 1'(t))) begin
          any_req = 1'b1;
          pick = idx;
        end
      end
    end

    // a new packet starts only from idle, which leaves one idle cycle between packets
    assign take = (state_reg == ST_IDLE) && any_req && load;

    always_comb begin
      grant_w[t] = '0;
      grant_w[t][pick] = take;
      pay_rdy_w[t] = '0;
      pay_rdy_w[t][sel_reg] = (state_reg == ST_PAY) && load;
    end

    // identifier and header fields for the chosen port
    always_comb begin
      id_byte = req_twelve_bit_i[pick] ? twelve_bit_id_reg[pick] : ten_bit_id_reg[pick];
      in_vc = id_byte[VC_LSB +: VC_W];
      out_vc = remap_reg[pick][VC_W*in_vc +: VC_W];
      dt = req_long_i[pick] ? id_byte[DT_W-1:0]
                            : cpvm_short_dt(req_sync_i[2*pick +: 2]);
      wc = req_wc_i[16*pick +: 16];
    end

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        state_reg <= ST_IDLE;
        sel_reg <= '0;
        rr_reg <= '0;
        hdr_reg <= '0;
        hdr_cnt_reg <= '0;
        is_long_reg <= 1'b0;
        left_reg <= '0;
        crc_reg <= CRC_SEED;
        ftr_cnt_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (take) begin
              sel_reg <= pick;
              rr_reg <= pick;
              is_long_reg <= req_long_i[pick];
              left_reg <= wc;
              crc_reg <= CRC_SEED;
              // bytes leave low first: identifier, count low, count high, code
              hdr_reg <= {cpvm_ecc({wc, out_vc, dt}), wc, out_vc, dt};
              hdr_cnt_reg <= '0;
              state_reg <= ST_HDR;
            end
          end
          ST_HDR: begin
            if (load) begin
              hdr_reg <= hdr_reg >> 8;
              hdr_cnt_reg <= hdr_cnt_reg + 2'h1;
              if (hdr_cnt_reg == HDR_LAST) begin
                if (!is_long_reg) begin
                  state_reg <= ST_IDLE;
                end else if (left_reg == 16'h0000) begin
                  state_reg <= ST_FTR;
                end else begin
                  state_reg <= ST_PAY;
                end
                ftr_cnt_reg <= 1'b0;
              end
            end
          end
          ST_PAY: begin
            if (load && pay_valid_i[sel_reg]) begin
              crc_reg <= cpvm_crc(crc_reg, pay_data_i[8*sel_reg +: 8]);
              left_reg <= left_reg - 16'h0001;
              if (left_reg == 16'h0001) begin
                state_reg <= ST_FTR;
              end
            end
          end
          ST_FTR: begin
            if (load) begin
              ftr_cnt_reg <= 1'b1;
              if (ftr_cnt_reg) begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end

    // output byte stage; the engine stalls whenever the stage holds an unsent byte
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        out_valid_reg <= 1'b0;
        out_data_reg <= 8'h00;
        out_first_reg <= 1'b0;
        out_last_reg <= 1'b0;
      end else if (load) begin
        out_valid_reg <= 1'b0;
        out_first_reg <= 1'b0;
        out_last_reg <= 1'b0;
        case (state_reg)
          ST_HDR: begin
            out_valid_reg <= 1'b1;
            out_data_reg <= hdr_reg[7:0];
            out_first_reg <= (hdr_cnt_reg == 2'h0);
            out_last_reg <= (hdr_cnt_reg == HDR_LAST) && !is_long_reg;
          end
          ST_PAY: begin
            out_valid_reg <= pay_valid_i[sel_reg];
            out_data_reg <= pay_data_i[8*sel_reg +: 8];
          end
          ST_FTR: begin
            out_valid_reg <= 1'b1;
            out_data_reg <= ftr_cnt_reg ? crc_reg[15:8] : crc_reg[7:0];
            out_last_reg <= ftr_cnt_reg;
          end
          default: ;
        endcase
      end
    end

    assign tx_valid_o[t] = out_valid_reg;
    assign tx_data_o[8*t +: 8] = out_data_reg;
    assign tx_first_o[t] = out_first_reg;
    assign tx_last_o[t] = out_last_reg;
  end

endmodule

/* hw/cpvm_pkg.sv */
// constants, types and code generators for the packet framer and channel mapper
package cpvm_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int NUM_TX = 2;
  localparam int PORT_W = 2;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_LANE_RATE = 8'h1F;
  localparam logic [7:0] ADDR_PORT_TX = 8'h21;
  localparam logic [7:0] ADDR_TIMING_OVR = 8'h22;
  localparam logic [7:0] ADDR_STATUS = 8'h23;
  localparam logic [7:0] ADDR_TEN_BIT_ID = 8'h70;
  localparam logic [7:0] ADDR_TWELVE_BIT_ID = 8'h71;
  localparam logic [7:0] ADDR_REMAP = 8'h72;

  // ----------------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_STREAM_ID = 8'h00;
  localparam logic [7:0] RST_REMAP = 8'hE4;
  localparam logic [1:0] RST_LANE_RATE = 2'h0;
  localparam logic [3:0] RST_PORT_TX = 4'h0;
  localparam logic RST_TIMING_OVR = 1'b0;
  localparam int VC_LSB = 6;
  localparam int VC_W = 2;
  localparam int DT_W = 6;
  localparam int RATE_W = 2;

  // ----------------------------------------------------------------------
  // lane rate codes and short packet data types
  // ----------------------------------------------------------------------
  localparam logic [1:0] RATE_1G6 = 2'h0;
  localparam logic [1:0] RATE_RESERVED = 2'h1;
  localparam logic [1:0] RATE_800M = 2'h2;
  localparam logic [1:0] RATE_400M = 2'h3;
  localparam logic [5:0] DT_FRAME_START = 6'h00;
  localparam logic [5:0] DT_FRAME_END = 6'h01;
  localparam logic [5:0] DT_LINE_START = 6'h02;
  localparam logic [5:0] DT_LINE_END = 6'h03;

  // ----------------------------------------------------------------------
  // header code and payload checksum
  // ----------------------------------------------------------------------
  localparam int ECC_BITS = 6;
  localparam logic [23:0] ECC_MASK [ECC_BITS] = '{
    24'hF12CB7, 24'hF2555B, 24'h749A6D, 24'hB8E38E, 24'hDF03F0, 24'hEFFC00};
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [1:0] HDR_LAST = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PAY, ST_FTR} cpvm_state_t;

  function automatic logic [7:0] cpvm_ecc(input logic [23:0] d);
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < ECC_BITS; i++) begin
      e[i] = ^(d & ECC_MASK[i]);
    end
    return e;
  endfunction

  // reflected polynomial, low bit of each byte enters first
  function automatic logic [15:0] cpvm_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ b[i]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] cpvm_short_dt(input logic [1:0] code);
    logic [5:0] dt;
    case (code)
      2'h0: dt = DT_FRAME_START;
      2'h1: dt = DT_FRAME_END;
      2'h2: dt = DT_LINE_START;
      default: dt = DT_LINE_END;
    endcase
    return dt;
  endfunction

endpackage

/* sim/cpvm_mapper_checker.sv */
// port assertions for the packet framer and channel mapper
module cpvm_mapper_checker
  import cpvm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [1:0] reg_port_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [cpvm_pkg::NUM_PORTS-1:0] req_valid_i,
  input wire logic [cpvm_pkg::NUM_PORTS-1:0] req_ready_o,
  input wire logic [cpvm_pkg::NUM_TX-1:0] tx_valid_o,
  input wire logic [8*cpvm_pkg::NUM_TX-1:0] tx_data_o,
  input wire logic [cpvm_pkg::NUM_TX-1:0] tx_first_o,
  input wire logic [cpvm_pkg::NUM_TX-1:0] tx_last_o,
  input wire logic [cpvm_pkg::NUM_TX-1:0] tx_ready_i,
  input wire logic [1:0] lane_rate_o,
  input wire logic timing_auto_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_tx0_hold_byte: assert property (tx_valid_o[0] && !tx_ready_i[0] |=>
    tx_valid_o[0] && $stable(tx_data_o[7:0]) && $stable(tx_last_o[0]))
    else $error("tx0 byte changed while stalled");
  a_tx1_hold_byte: assert property ((tx_valid_o[1] && !tx_ready_i[1]) ##1 1'b1 |->
    tx_valid_o[1] && $stable(tx_data_o[15:8])) else $error("tx1 byte changed while stalled");
  a_gap_after_last: assert property (tx_valid_o[0] && tx_ready_i[0] && tx_last_o[0] |=>
    !tx_valid_o[0]) else $error("no idle cycle after packet end");
  a_first_not_last: assert property (tx_valid_o[0] && tx_first_o[0] |-> !tx_last_o[0])
    else $error("header byte flagged as last");
  a_grant_needs_req: assert property ((req_ready_o & ~req_valid_i) == 4'h0)
    else $error("grant without request");
  a_rate_write: assert property (reg_wr_i && reg_addr_i == ADDR_LANE_RATE |=>
    lane_rate_o == $past(reg_wdata_i[1:0])) else $error("rate field not written");
  a_auto_off_rate: assert property (lane_rate_o[0] |-> !timing_auto_o)
    else $error("automatic timing at reserved or low rate");
  a_unmapped_zero: assert property (reg_addr_i == 8'h00 |=> reg_rdata_o == 8'h00)
    else $error("unmapped offset read nonzero");
  a_id_readback: assert property (reg_wr_i && reg_addr_i == ADDR_TEN_BIT_ID ##1
    (!reg_wr_i && $stable(reg_addr_i) && $stable(reg_port_i)) |=>
    reg_rdata_o == $past(reg_wdata_i, 2)) else $error("identifier readback wrong");
  c_tx1_packet: cover property (tx_valid_o[1] && tx_first_o[1]);
  c_tx0_stall: cover property (tx_valid_o[0] && !tx_ready_i[0]);
  c_remap_write: cover property (reg_wr_i && reg_addr_i == ADDR_REMAP);
endmodule

bind cpvm_mapper cpvm_mapper_checker cpvm_mapper_checker_i (.clk_i, .reset_i, .reg_wr_i,
  .reg_addr_i, .reg_port_i, .reg_wdata_i, .reg_rdata_o, .req_valid_i, .req_ready_o,
  .tx_valid_o, .tx_data_o, .tx_first_o, .tx_last_o, .tx_ready_i, .lane_rate_o,
  .timing_auto_o);

/* sim/cpvm_rx_model.sv */
// receiving end of one transmitter link: byte sink that can stall
module cpvm_rx_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic first_i,
  input wire logic last_i,
  output logic ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] q [$];
  logic [1:0] cnt_reg = 2'h0;
  // slow mode takes one byte in four on a free-running count, so any byte, the first of a packet included, can see stalls
  assign ready_o = !slow_i || (cnt_reg == 2'h3);
  always @(posedge clk_i) begin
    cnt_reg <= cnt_reg + 2'h1;
    if (valid_i && ready_o) begin
      q.push_back({first_i, last_i, data_i});
    end
  end
endmodule

/* sim/tb_top.sv */
// self-checking bench for the packet framer and channel mapper
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cpvm_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic slow = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, req_sync_i = 8'h00;
  logic [1:0] reg_port_i = 2'h0, lane_rate_o, tx_ready_i, tx_valid_o, tx_first_o, tx_last_o;
  logic [3:0] req_valid_i = 4'h0, req_long_i = 4'h0, req_twelve_bit_i = 4'h0, pay_valid_i = 4'h0;
  logic [3:0] req_ready_o, pay_ready_o;
  logic [63:0] req_wc_i = 64'h0;
  logic [31:0] pay_data_i = 32'h0;
  logic [15:0] tx_data_o;
  logic timing_auto_o;
  int num_errors = 0;
  int compares = 0;
  cpvm_mapper cpvm_mapper_i (.clk_i, .reset_i, .reg_wr_i, .reg_addr_i, .reg_port_i,
    .reg_wdata_i, .reg_rdata_o, .req_valid_i, .req_long_i, .req_twelve_bit_i, .req_sync_i,
    .req_wc_i, .req_ready_o, .pay_valid_i, .pay_data_i, .pay_ready_o, .tx_valid_o,
    .tx_data_o, .tx_first_o, .tx_last_o, .tx_ready_i, .lane_rate_o, .timing_auto_o);
  cpvm_rx_model cpvm_rx_model_i [1:0] (.clk_i, .slow_i(slow), .valid_i(tx_valid_o),
    .data_i(tx_data_o), .first_i(tx_first_o), .last_i(tx_last_o), .ready_o(tx_ready_i));
  initial forever #5 clk_i = ~clk_i;
  task automatic results();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic fail();
    num_errors++;
    $display("MISMATCH at %0t: wait ran out", $time);
    results();
  endtask
  task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [1:0] p, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_port_i = p;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] p, input logic [7:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_port_i = p;
    @(negedge clk_i);
    check({2'h0, reg_rdata_o}, {2'h0, e}, "register read");
  endtask
  // request is held until granted, each byte until taken
  task automatic send(input int p, input logic lng, input logic r12, input logic [1:0] sc,
      input logic [15:0] wc, input logic [7:0] sd);
    int n;
    n = 0;
    @(negedge clk_i);
    req_valid_i[p] = 1'b1;
    req_long_i[p] = lng;
    req_twelve_bit_i[p] = r12;
    req_sync_i[2*p +: 2] = sc;
    req_wc_i[16*p +: 16] = wc;
    #1;
    while (req_ready_o[p] !== 1'b1) begin
      @(negedge clk_i);
      #1;
      if (++n > 2000) fail();
    end
    @(negedge clk_i);
    req_valid_i[p] = 1'b0;
    for (int i = 0; lng && i < wc; i++) begin
      pay_valid_i[p] = 1'b1;
      pay_data_i[8*p +: 8] = sd + 8'(i) * 8'h3B;
      #1;
      while (pay_ready_o[p] !== 1'b1) begin
        @(negedge clk_i);
        #1;
        if (++n > 2000) fail();
      end
      @(negedge clk_i);
    end
    pay_valid_i[p] = 1'b0;
  endtask
  task automatic expect_pkt(input int t, input logic lng, input logic [7:0] di,
      input logic [15:0] wc, input logic [7:0] sd);
    logic [7:0] e [$];
    logic [7:0] ecc;
    logic [7:0] b;
    logic [15:0] c;
    logic [9:0] g;
    int n;
    n = 0;
    ecc = 8'h00;
    for (int i = 0; i < ECC_BITS; i++) begin
      ecc[i] = ^({wc, di} & ECC_MASK[i]);
    end
    e = '{di, wc[7:0], wc[15:8], ecc};
    c = CRC_SEED;
    for (int i = 0; lng && i < wc; i++) begin
      b = sd + 8'(i) * 8'h3B;
      e.push_back(b);
      for (int k = 0; k < 8; k++) begin
        c = (c[0] ^ b[k]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    if (lng) begin
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    foreach (e[i]) begin
      while ((t ? cpvm_rx_model_i[1].q.size() : cpvm_rx_model_i[0].q.size()) == 0) begin
        @(posedge clk_i);
        if (++n > 3000) fail();
      end
      g = t ? cpvm_rx_model_i[1].q.pop_front() : cpvm_rx_model_i[0].q.pop_front();
      check(g, {i == 0, i == e.size() - 1, e[i]}, "link byte");
    end
  endtask
  task automatic t_regs();
    rd(ADDR_TEN_BIT_ID, 2'h0, RST_STREAM_ID);
    rd(ADDR_REMAP, 2'h1, RST_REMAP);
    rd(8'h00, 2'h0, 8'h00);
    wr(ADDR_TEN_BIT_ID, 2'h1, 8'h45);
    rd(ADDR_TEN_BIT_ID, 2'h1, 8'h45);
    rd(ADDR_TWELVE_BIT_ID, 2'h1, RST_STREAM_ID);
    $display("test regs done");
  endtask
  task automatic t_rates();
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_LANE_RATE, 2'h0, 8'(r));
      check({8'h00, lane_rate_o}, 10'(r), "rate");
      check({9'h000, timing_auto_o}, {9'h000, r == 0 || r == 2}, "auto timing");
    end
    wr(ADDR_TIMING_OVR, 2'h0, 8'h01);
    rd(ADDR_TIMING_OVR, 2'h0, 8'h01);
    wr(ADDR_LANE_RATE, 2'h0, 8'h02);
    check({9'h000, timing_auto_o}, 10'h000, "override");
    wr(ADDR_TIMING_OVR, 2'h0, 8'h00);
    check({9'h000, timing_auto_o}, 10'h001, "auto timing");
    $display("test rates done");
  endtask
  task automatic t_remap();
    slow = 1'b1;
    wr(ADDR_TEN_BIT_ID, 2'h1, 8'hAB);
    wr(ADDR_REMAP, 2'h1, 8'hD4);
    fork
      send(1, 1'b1, 1'b0, 2'h0, 16'h0005, 8'hFB);
      expect_pkt(0, 1'b1, 8'h6B, 16'h0005, 8'hFB);
    join
    wr(ADDR_TWELVE_BIT_ID, 2'h1, 8'h2C);
    fork
      send(1, 1'b1, 1'b1, 2'h0, 16'h0000, 8'h00);
      expect_pkt(0, 1'b1, 8'h2C, 16'h0000, 8'h00);
    join
    $display("test remap done");
  endtask
  task automatic t_short();
    @(negedge clk_i);
    slow = 1'b0;
    for (int s = 0; s < 4; s++) begin
      send(0, 1'b0, 1'b0, 2'(s), 16'h1234 + 16'(s), 8'h00);
      rd(ADDR_STATUS, 2'h0, 8'h01);
      expect_pkt(0, 1'b0, 8'(s), 16'h1234 + 16'(s), 8'h00);
    end
    $display("test short done");
  endtask
  task automatic t_steer();
    @(negedge clk_i);
    slow = 1'b1;
    wr(ADDR_PORT_TX, 2'h0, 8'h08);
    rd(ADDR_PORT_TX, 2'h0, 8'h08);
    wr(ADDR_TEN_BIT_ID, 2'h0, 8'h2B);
    wr(ADDR_TEN_BIT_ID, 2'h2, 8'h2B);
    wr(ADDR_TEN_BIT_ID, 2'h3, 8'h2B);
    wr(ADDR_REMAP, 2'h2, 8'hE6);
    wr(ADDR_REMAP, 2'h3, 8'hE7);
    fork
      send(0, 1'b1, 1'b0, 2'h0, 16'h0003, 8'h10);
      begin
        @(negedge clk_i);
        send(2, 1'b1, 1'b0, 2'h0, 16'h0002, 8'hC0);
      end
      send(3, 1'b1, 1'b0, 2'h0, 16'h0004, 8'hF0);
      begin
        expect_pkt(0, 1'b1, 8'h2B, 16'h0003, 8'h10);
        expect_pkt(0, 1'b1, 8'hAB, 16'h0002, 8'hC0);
      end
      expect_pkt(1, 1'b1, 8'hEB, 16'h0004, 8'hF0);
    join
    $display("test steer done");
  endtask
  // mid-run reset: links go idle, and lane rate, port steering and port 2 remap must return to their reset values
  task automatic t_reset();
    @(negedge clk_i);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    check({8'h00, tx_valid_o}, 10'h000, "link idle after reset");
    rd(ADDR_LANE_RATE, 2'h0, 8'(RST_LANE_RATE));
    rd(ADDR_PORT_TX, 2'h0, 8'(RST_PORT_TX));
    rd(ADDR_REMAP, 2'h2, RST_REMAP);
    $display("test reset done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    t_regs();
    t_rates();
    t_remap();
    t_short();
    t_steer();
    t_reset();
    results();
  end
endmodule
